// [core/pmdis_pkg.sv]
package pmdis_pkg;

  // ******************************************************
  // Register map (printed offsets are word indices)
  // ******************************************************
  localparam int          NUM_REGS   = 6;
  localparam int          REG_W      = 8;
  localparam int          NUM_BITS   = NUM_REGS * REG_W;
  localparam int          IDX_W      = 12;
  localparam logic [11:0] IDX_SYSTEM = 12'hEE1;
  localparam logic [11:0] IDX_TIMERS = 12'hEE2;
  localparam logic [11:0] IDX_ANALOG = 12'hEE3;
  localparam logic [11:0] IDX_PWMCAP = 12'hEE4;
  localparam logic [11:0] IDX_SERIAL = 12'hEE5;
  localparam logic [11:0] IDX_MODUL  = 12'hEE6;
  localparam logic [11:0] REG_IDX [0:NUM_REGS-1] =
    '{IDX_SYSTEM, IDX_TIMERS, IDX_ANALOG, IDX_PWMCAP, IDX_SERIAL, IDX_MODUL};
  // Implemented bit positions; all others read zero and drop writes
  localparam logic [7:0]  REG_MASK [0:NUM_REGS-1] =
    '{8'hFF, 8'h7F, 8'h67, 8'h0F, 8'hF1, 8'h01};
  localparam logic [7:0]  REG_RESET  = 8'h00;

  // ******************************************************
  // Bit positions in the flat disable vector
  // ******************************************************
  localparam int BIT_PIN_CHANGE_IRQ = 0;
  localparam int BIT_REF_CLOCK_OUT  = 1;
  localparam int BIT_NONVOL_MEM     = 2;
  localparam int BIT_MEM_SCANNER    = 3;
  localparam int BIT_CHECKSUM       = 4;
  localparam int BIT_VOLT_DETECT    = 5;
  localparam int BIT_VOLT_REF       = 6;
  localparam int BIT_SYS_CLOCK_NET  = 7;
  localparam int BIT_TIMER_0        = 8;
  localparam int BIT_ZERO_CROSS     = 16;
  localparam int BIT_COMPARATOR_1   = 17;
  localparam int BIT_COMPARATOR_2   = 18;
  localparam int BIT_ANALOG_TO_DIG  = 21;
  localparam int BIT_DIG_TO_ANALOG  = 22;
  localparam int BIT_CAPTURE_CMP_1  = 24;
  localparam int BIT_CAPTURE_CMP_2  = 25;
  localparam int BIT_PULSE_MOD_3    = 26;
  localparam int BIT_PULSE_MOD_4    = 27;
  localparam int BIT_WAVEFORM_GEN   = 32;
  localparam int BIT_SYNC_SERIAL_1  = 36;
  localparam int BIT_SYNC_SERIAL_2  = 37;
  localparam int BIT_SERIAL_PORT_1  = 38;
  localparam int BIT_SERIAL_PORT_2  = 39;
  localparam int BIT_SIGNAL_MOD     = 40;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int INSTR_CLKS        = 4;
  localparam int NVM_SETTLE_NS     = 1;
  localparam int NVM_SETTLE_CLKS   = (NVM_SETTLE_NS * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS / 1000 * 0
                                     + (NVM_SETTLE_NS * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W             = 9;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic        HRESP_OKAY    = 1'h0;

  // ******************************************************
  // Per-peripheral control bundle
  // ******************************************************
  typedef struct packed {
    logic [NUM_BITS-1:0] clk_en;
    logic [NUM_BITS-1:0] rst_hold;
    logic [NUM_BITS-1:0] sfr_block;
    logic [NUM_BITS-1:0] dout_low;
    logic [NUM_BITS-1:0] analog_off;
    logic [NUM_BITS-1:0] active;
  } pmdis_ctl_t;

endpackage : pmdis_pkg

// [core/pmdis_top.sv]
`timescale 1ns/100ps
module pmdis_top #(
  parameter int INSTR_CLKS      = pmdis_pkg::INSTR_CLKS,
  parameter int NVM_SETTLE_CLKS = pmdis_pkg::NVM_SETTLE_CLKS
) (
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic      [31:0]                        hrdata,
  output logic                                    hreadyout,
  output logic                                    hresp,
  input  wire logic                               scanner_config_enable,
  input  wire logic                               zero_cross_config_on,
  output logic                                    sys_clock_net_en,
  output logic                                    nonvolatile_mem_block,
  output logic                                    memory_control_ro,
  output logic                                    nonvolatile_mem_ready,
  output pmdis_pkg::pmdis_ctl_t                   periph_ctl
);

  localparam int NB = pmdis_pkg::NUM_BITS;

  // ******************************************************
  // AHB-Lite slave
  // ******************************************************
  logic                          wr_pend_q;
  logic                          wr_pend_d;
  logic [pmdis_pkg::IDX_W-1:0]   wr_idx_q;
  logic [31:0]                   hrdata_q;
  logic [31:0]                   hrdata_d;
  logic [NB-1:0]                 dis_q;
  logic [NB-1:0]                 dis_d;
  logic [pmdis_pkg::NUM_REGS-1:0] rd_hit;
  logic [pmdis_pkg::NUM_REGS-1:0] wr_hit;
  logic [7:0]                    rd_byte [0:pmdis_pkg::NUM_REGS-1];

  wire logic                     xfer_ok  = hsel && hready && (htrans == pmdis_pkg::HTRANS_NONSEQ ||
                                                               htrans == pmdis_pkg::HTRANS_SEQ);
  wire logic [pmdis_pkg::IDX_W-1:0] addr_idx = haddr[pmdis_pkg::IDX_W+1:2];

  assign wr_pend_d = xfer_ok && hwrite;

  genvar r;
  generate
    for (r = 0; r < pmdis_pkg::NUM_REGS; r++) begin : g_reg
      // Writes land in the data phase; unimplemented bits never store
      assign wr_hit[r] = wr_pend_q && (wr_idx_q == pmdis_pkg::REG_IDX[r]);
      assign dis_d[r*8 +: 8] = wr_hit[r] ? (hwdata[7:0] & pmdis_pkg::REG_MASK[r]) : dis_q[r*8 +: 8];
      assign rd_hit[r] = xfer_ok && !hwrite && (addr_idx == pmdis_pkg::REG_IDX[r]);
      // A read right behind a write to the same register sees the new value
      assign rd_byte[r] = wr_hit[r] ? dis_d[r*8 +: 8] : dis_q[r*8 +: 8];
    end
  endgenerate

  // Layout of all six registers is fixed by the flat bit map
  always_comb begin
    hrdata_d = 32'h0000_0000;
    if (rd_hit[0]) begin
      hrdata_d[7:0] = rd_byte[0];
    end else if (rd_hit[1]) begin
      hrdata_d[7:0] = rd_byte[1];
    end else if (rd_hit[2]) begin
      hrdata_d[7:0] = rd_byte[2];
    end else if (rd_hit[3]) begin
      hrdata_d[7:0] = rd_byte[3];
    end else if (rd_hit[4]) begin
      hrdata_d[7:0] = rd_byte[4];
    end else if (rd_hit[5]) begin
      hrdata_d[7:0] = rd_byte[5];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= '0;
      hrdata_q  <= 32'h0000_0000;
      dis_q     <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q  <= addr_idx;
      hrdata_q  <= hrdata_d;
      dis_q     <= dis_d;
    end
  end

  // Zero wait states, so ready and response are constant flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= pmdis_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= pmdis_pkg::HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;

  // ******************************************************
  // Effective disables
  // ******************************************************
  logic [NB-1:0] eff_off;

  always_comb begin
    eff_off = dis_q;
    // Scanner bit only matters when the scanner is configured
    eff_off[pmdis_pkg::BIT_MEM_SCANNER] = dis_q[pmdis_pkg::BIT_MEM_SCANNER] || !scanner_config_enable;
    // Zero-cross forced on by configuration overrides its bit
    eff_off[pmdis_pkg::BIT_ZERO_CROSS]  = dis_q[pmdis_pkg::BIT_ZERO_CROSS] && !zero_cross_config_on;
    // The network bit is not a peripheral; quarter-rate users keep clocks
    eff_off[pmdis_pkg::BIT_SYS_CLOCK_NET] = 1'b0;
  end

  // ******************************************************
  // Re-enable settling, one counter per bit
  // ******************************************************
  logic [NB-1:0] active_q;
  logic [NB-1:0] eff_off_q;

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bit
      localparam logic [pmdis_pkg::CNT_W-1:0] SETTLE = (b == pmdis_pkg::BIT_NONVOL_MEM) ?
        pmdis_pkg::CNT_W'(NVM_SETTLE_CLKS) : pmdis_pkg::CNT_W'(INSTR_CLKS);
      logic [pmdis_pkg::CNT_W-1:0] cnt_q;
      logic [pmdis_pkg::CNT_W-1:0] cnt_d;
      logic                        act_d;

      // Count restarts on every disable so re-enable always begins from SETTLE
      assign cnt_d = eff_off[b] ? SETTLE :
                     (cnt_q != '0) ? cnt_q - pmdis_pkg::CNT_W'(1) : cnt_q;
      assign act_d = !eff_off[b] && (cnt_q == '0 || cnt_q == pmdis_pkg::CNT_W'(1));

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_q       <= '0;
          active_q[b] <= 1'b1;
        end else begin
          cnt_q       <= cnt_d;
          active_q[b] <= act_d;
        end
      end
    end
  endgenerate

  // ******************************************************
  // Registered control outputs
  // ******************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eff_off_q             <= '0;
      sys_clock_net_en      <= 1'b1;
      nonvolatile_mem_block <= 1'b0;
      memory_control_ro     <= 1'b0;
      nonvolatile_mem_ready <= 1'b1;
    end else begin
      eff_off_q             <= eff_off;
      sys_clock_net_en      <= !dis_q[pmdis_pkg::BIT_SYS_CLOCK_NET];
      nonvolatile_mem_block <= dis_q[pmdis_pkg::BIT_NONVOL_MEM];
      memory_control_ro     <= dis_q[pmdis_pkg::BIT_NONVOL_MEM];
      // Software must still hold off until this rises
      nonvolatile_mem_ready <= active_q[pmdis_pkg::BIT_NONVOL_MEM] && !eff_off[pmdis_pkg::BIT_NONVOL_MEM];
    end
  end

  assign periph_ctl.clk_en     = ~eff_off_q;
  assign periph_ctl.rst_hold   = eff_off_q;
  assign periph_ctl.sfr_block  = eff_off_q;
  assign periph_ctl.dout_low   = eff_off_q;
  assign periph_ctl.analog_off = eff_off_q;
  assign periph_ctl.active     = active_q;

endmodule : pmdis_top

// [tb/pmdis_assertions.sv]
`timescale 1ns/100ps
module pmdis_assertions #(
  parameter int INSTR_CLKS      = 4,
  parameter int NVM_SETTLE_CLKS = 4
) (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  nonvolatile_mem_block,
  input wire logic                  memory_control_ro,
  input wire logic                  nonvolatile_mem_ready,
  input wire pmdis_pkg::pmdis_ctl_t periph_ctl
);
  // ******************************************************
  // Port relations
  // ******************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_clk_gate: assert property (periph_ctl.clk_en == ~periph_ctl.rst_hold)
    else $error("clock enable not inverse of reset hold");
  // Config-driven bits excluded: their gate may move before the settle flag
  a_held_inactive: assert property ((periph_ctl.rst_hold & periph_ctl.active & ~48'h0000_0001_0008) == 48'h0)
    else $error("held peripheral shows active");
  a_sfr_block: assert property (periph_ctl.sfr_block == periph_ctl.rst_hold)
    else $error("register block differs from reset hold");
  a_outputs_low: assert property (periph_ctl.dout_low == periph_ctl.rst_hold && periph_ctl.analog_off == periph_ctl.rst_hold)
    else $error("output shutdown differs from reset hold");
  a_settle_time: assert property ($fell(periph_ctl.rst_hold[8]) |-> !periph_ctl.active[8] [*2] ##[1:INSTR_CLKS] periph_ctl.active[8])
    else $error("timer settle time wrong");
  a_net_bit: assert property (periph_ctl.clk_en[7] && !periph_ctl.rst_hold[7])
    else $error("network bit leaked into peripheral gates");
  a_mem_lock: assert property (nonvolatile_mem_block == memory_control_ro && nonvolatile_mem_block == periph_ctl.rst_hold[2])
    else $error("memory lock outputs disagree");
  a_mem_ready: assert property ($fell(nonvolatile_mem_block) |-> !nonvolatile_mem_ready ##[1:NVM_SETTLE_CLKS] nonvolatile_mem_ready)
    else $error("memory ready timing wrong");
  a_bus_okay: assert property (hreadyout && hresp == 1'b0 && hrdata[31:8] == 24'h0)
    else $error("bus response or upper read bits wrong");
endmodule : pmdis_assertions
bind pmdis_top pmdis_assertions #(.INSTR_CLKS(INSTR_CLKS), .NVM_SETTLE_CLKS(NVM_SETTLE_CLKS)) pmdis_assertions_inst (
  .hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .nonvolatile_mem_block(nonvolatile_mem_block), .memory_control_ro(memory_control_ro),
  .nonvolatile_mem_ready(nonvolatile_mem_ready), .periph_ctl(periph_ctl));

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  // ******************************************************
  // Signals and model
  // ******************************************************
  logic                  hclk = 1'b0;
  logic                  hresetn = 1'b0;
  logic                  hsel = 1'b0;
  logic [31:0]           haddr = 32'h0;
  logic [1:0]            htrans = 2'h0;
  logic                  hwrite = 1'b0;
  logic [31:0]           hwdata = 32'h0;
  logic                  scanner_config_enable = 1'b1;
  logic                  zero_cross_config_on = 1'b0;
  logic [31:0]           hrdata;
  logic                  hreadyout;
  logic                  hresp;
  logic                  sys_clock_net_en;
  logic                  nonvolatile_mem_block;
  logic                  memory_control_ro;
  logic                  nonvolatile_mem_ready;
  pmdis_pkg::pmdis_ctl_t periph_ctl;
  logic [7:0]            model [0:5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]            mask [0:5] = '{8'hFF, 8'h7F, 8'h67, 8'h0F, 8'hF1, 8'h01};
  logic [31:0]           rd;
  logic [47:0]           e;
  logic [7:0]            d;
  int                    k;
  int                    num_errors = 0;
  int                    cmp_count = 0;
  pmdis_top #(.INSTR_CLKS(4), .NVM_SETTLE_CLKS(4)) pmdis_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scanner_config_enable(scanner_config_enable), .zero_cross_config_on(zero_cross_config_on),
    .sys_clock_net_en(sys_clock_net_en), .nonvolatile_mem_block(nonvolatile_mem_block),
    .memory_control_ro(memory_control_ro), .nonvolatile_mem_ready(nonvolatile_mem_ready),
    .periph_ctl(periph_ctl));
  initial begin
    forever #2 hclk = ~hclk;
  end
  // ******************************************************
  // Tasks
  // ******************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // Bounded wait; a hung slave ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        num_errors++;
        final_report();
      end
      @(posedge hclk);
    end
  endtask : wait_ready
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'h0};
    htrans <= pmdis_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
    q = hrdata;
  endtask : bus
  task automatic wr_reg(input int r, input logic [7:0] wd);
    bus(1'b1, 12'hEE1 + r[11:0], wd, rd);
    model[r] = wd & mask[r];
  endtask : wr_reg
  task automatic read_all();
    for (int r = 0; r < 6; r++) begin
      bus(1'b0, 12'hEE1 + r[11:0], 8'h00, rd);
      check(rd, {24'h0, model[r]});
    end
  endtask : read_all
  // Gates land one edge after the register; compare off the edge
  task automatic check_ctl();
    repeat (2) @(posedge hclk);
    #1;
    e = {model[5], model[4], model[3], model[2], model[1], model[0]} & ~48'h80;
    e[3] = e[3] | ~scanner_config_enable;
    e[16] = e[16] & ~zero_cross_config_on;
    check(periph_ctl.rst_hold, e);
    e = ~e;
    check(periph_ctl.clk_en, e);
    check(sys_clock_net_en, !model[0][7]);
    check(nonvolatile_mem_block, model[0][2]);
    check(memory_control_ro, model[0][2]);
    @(posedge hclk);
  endtask : check_ctl
  // ******************************************************
  // Sequence
  // ******************************************************
  initial begin
    rd = $urandom(57360);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    read_all();
    check_ctl();
    bus(1'b1, 12'hEE7, 8'hFF, rd);
    bus(1'b0, 12'hEE7, 8'h00, rd);
    check(rd, 32'h0);
    wr_reg(1, 8'hFF);
    wr_reg(1, 8'h00);
    // Software keeps off the timer until it has settled
    repeat (3) @(posedge hclk);
    #1;
    check(periph_ctl.active[8], 1'b0);
    @(posedge hclk);
    #1;
    check(periph_ctl.active[8], 1'b1);
    check_ctl();
    wr_reg(0, 8'h04);
    wr_reg(0, 8'h00);
    // Memory is only touched once its settle time has run out
    repeat (5) @(posedge hclk);
    #1;
    check(nonvolatile_mem_ready, 1'b1);
    $display("test reset_unmapped done");
    for (int i = 0; i < 60; i++) begin
      k = $urandom_range(5);
      d = $urandom;
      scanner_config_enable <= $urandom;
      zero_cross_config_on <= $urandom;
      wr_reg(k, d);
      check_ctl();
      bus(1'b0, 12'hEE1 + k[11:0], 8'h00, rd);
      check(rd, {24'h0, model[k]});
    end
    $display("test random_access done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int r = 0; r < 6; r++) model[r] = 8'h00;
    check_ctl();
    read_all();
    $display("test mid_reset done");
    final_report();
  end
endmodule : tb_top
